// ==== src/wcd_pkg.sv ====
// Constants, types and the mode decode shared by the wheel command word decoder
`default_nettype none
package wcd_pkg;

  // ***************************************************************
  // Command word layout
  // ***************************************************************
  localparam int WORD_BITS     = 37;
  localparam int CODE_BITS     = 8;
  localparam int MODE_BITS     = 4;
  localparam int PITCH_LSB     = 0;
  localparam int YAW_LSB       = 8;
  localparam int ROLL_LSB      = 16;
  localparam int REDUND_LSB    = 24;
  localparam int XFER_BIT      = 32;
  localparam int MODE_LSB      = 33;
  localparam int ENABLE_BITS   = 6;
  localparam int COUNT_BITS    = 16;

  // ***************************************************************
  // Register map (byte addresses) and fields
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_WHEELS  = 8'h08;
  localparam logic [7:0] ADDR_WORDCNT = 8'h0C;
  localparam logic [7:0] ADDR_ERRCNT  = 8'h10;
  localparam int CTRL_RX_EN    = 0;
  localparam int CTRL_OUT_EN   = 1;
  localparam int CTRL_CLR_CNT  = 2;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_MODE_LSB = 6;
  localparam int STAT_XFER     = 10;

  // ***************************************************************
  // Mode codes and decoded enable pattern {sun, rateB, rateA, wheelC, wheelB, wheelA}
  // ***************************************************************
  typedef enum logic [3:0] {
    MODE_OFF      = 4'h0,
    MODE_WHEELS   = 4'h1,
    MODE_RATE_A   = 4'h2,
    MODE_RATE_AB  = 4'h3,
    MODE_SUN_ACQ  = 4'h4
  } wcd_mode_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01,
    RX_WAIT  = 2'b10
  } wcd_rx_state_type;

  // Undefined codes decode to all enables off, the safe state
  function automatic logic [ENABLE_BITS-1:0] decodeMode(input logic [MODE_BITS-1:0] mode);
    logic [ENABLE_BITS-1:0] en;
    en = 6'h00;
    unique case (mode)
      MODE_WHEELS:  en = 6'h07;
      MODE_RATE_A:  en = 6'h0F;
      MODE_RATE_AB: en = 6'h1F;
      MODE_SUN_ACQ: en = 6'h3F;
      default:      en = 6'h00;
    endcase
    return en;
  endfunction

endpackage
`default_nettype wire

// ==== src/wcd_serial_rx.sv ====
// Serial receiver: frames 37 command bits and delivers complete words only
`timescale 1ns/1ps
`default_nettype none
module wcd_serial_rx
  import wcd_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 rxEnable,
  input  wire logic                 serFrame,
  input  wire logic                 serStrobe,
  input  wire logic                 serData,
  output logic [WORD_BITS-1:0]      rxWord,
  output logic                      rxValid,
  output logic                      rxError
);
  import wcd_pkg::*;

  // ***************************************************************
  // Shift state
  // ***************************************************************
  wcd_rx_state_type      state_reg, state_next;
  logic [5:0]            bitCnt_reg, bitCnt_next;
  logic [WORD_BITS-1:0]  shift_reg, shift_next;
  logic [WORD_BITS-1:0]  word_reg, word_next;
  logic                  valid_reg, valid_next;
  logic                  error_reg, error_next;

  // Bit 1 arrives first and walks down to index 0
  always_comb
  begin
    state_next  = state_reg;
    bitCnt_next = bitCnt_reg;
    shift_next  = shift_reg;
    word_next   = word_reg;
    valid_next  = 1'b0;
    error_next  = 1'b0;
    unique case (state_reg)
      RX_IDLE:
      begin
        bitCnt_next = 6'h00;
        if (rxEnable && serFrame)
        begin
          state_next = RX_SHIFT;
          if (serStrobe)
          begin
            shift_next  = {serData, shift_reg[WORD_BITS-1:1]};
            bitCnt_next = 6'h01;
          end
        end
      end
      RX_SHIFT:
      begin
        if (!serFrame || !rxEnable)
        begin
          // Short frame: drop it and flag it on rxError, word and valid untouched
          state_next = RX_IDLE;
          error_next = 1'b1;
        end
        else if (serStrobe)
        begin
          shift_next  = {serData, shift_reg[WORD_BITS-1:1]};
          bitCnt_next = bitCnt_reg + 6'h01;
          if (bitCnt_reg == 6'(WORD_BITS - 1))
          begin
            // Whole word only, on its last bit
            word_next  = {serData, shift_reg[WORD_BITS-1:1]};
            valid_next = 1'b1;
            state_next = RX_WAIT;
          end
        end
      end
      RX_WAIT:
      begin
        // Bits beyond 37 are ignored but flagged
        if (serStrobe && serFrame)
          error_next = 1'b1;
        if (!serFrame)
          state_next = RX_IDLE;
      end
      default:
        state_next = RX_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg  <= RX_IDLE;
      bitCnt_reg <= 6'h00;
      shift_reg  <= 37'h0;
      word_reg   <= 37'h0;
      valid_reg  <= 1'b0;
      error_reg  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg  <= shift_next;
      word_reg   <= word_next;
      valid_reg  <= valid_next;
      error_reg  <= error_next;
    end
  end

  assign rxWord  = word_reg;
  assign rxValid = valid_reg;
  assign rxError = error_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence sLastBit;
    state_reg == RX_SHIFT && serFrame && rxEnable && serStrobe && bitCnt_reg == 6'd36;
  endsequence

  a_word_after_37: assert property (sLastBit |=> rxValid && rxWord[36] == $past(serData))
    else $error("word not delivered on bit 37");
  a_word_only_full: assert property (!$stable(word_reg) |-> rxValid && $past(bitCnt_reg) == 6'd36)
    else $error("holding word changed without a full word");
  a_bit_one_low: assert property (rxValid |-> rxWord[0] == $past(shift_reg[1]))
    else $error("first bit not at index 0");

endmodule
`default_nettype wire

// ==== src/wcd_top.sv ====
// Wheel command word decoder: holding register, drive codes, mode decode, APB status
//
// Functional notes
// - Capture 37-bit serial word into holding register
// - Bits 1-32 form four 8-bit drive codes
// - Order pitch, yaw, roll, redundant by bits
// - Lowest field bit is the code LSB
// - Mode field loads only when bit 33 set
// - Decode mode into wheel and mixing enables
// - Decoder state reported as telemetry status
// - Rate and sun enables gate mixing inputs
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wcd_top
  import wcd_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Serial command link
  input  wire logic                          serFrame,
  input  wire logic                          serStrobe,
  input  wire logic                          serData,
  // Converter codes
  output logic [wcd_pkg::CODE_BITS-1:0]      pitchCode,
  output logic [wcd_pkg::CODE_BITS-1:0]      yawCode,
  output logic [wcd_pkg::CODE_BITS-1:0]      rollCode,
  output logic [wcd_pkg::CODE_BITS-1:0]      redundCode,
  // Decoded enables
  output logic                               wheel_driver_enable_a,
  output logic                               wheel_driver_enable_b,
  output logic                               wheel_driver_enable_c,
  output logic                               rate_path_enable_a,
  output logic                               rate_path_enable_b,
  output logic                               sunSensorEnable,
  output logic [wcd_pkg::ENABLE_BITS-1:0]    modeTelemetry
);
  import wcd_pkg::*;

  // ***************************************************************
  // Serial receiver
  // ***************************************************************
  logic [WORD_BITS-1:0]  rxWord;
  logic                  rxValid;
  logic                  rxError;
  logic [1:0]            ctrl_reg, ctrl_next;

  wcd_serial_rx u_rx (
    .clock     (clock),
    .arst_n    (arst_n),
    .rxEnable  (ctrl_reg[CTRL_RX_EN]),
    .serFrame  (serFrame),
    .serStrobe (serStrobe),
    .serData   (serData),
    .rxWord    (rxWord),
    .rxValid   (rxValid),
    .rxError   (rxError)
  );

  // ***************************************************************
  // Holding register and decode
  // ***************************************************************
  logic [4*CODE_BITS-1:0]  codes_reg, codes_next;
  logic [MODE_BITS-1:0]    mode_reg, mode_next;
  logic                    xfer_reg, xfer_next;
  logic [ENABLE_BITS-1:0]  en_reg, en_next;

  // Codes follow every word; mode only with the transfer bit
  always_comb
  begin
    codes_next = codes_reg;
    mode_next  = mode_reg;
    xfer_next  = xfer_reg;
    if (rxValid)
    begin
      codes_next = rxWord[4*CODE_BITS-1:0];
      xfer_next  = rxWord[XFER_BIT];
      if (rxWord[XFER_BIT])
        mode_next = rxWord[MODE_LSB +: MODE_BITS];
    end
    // Output enable low parks every path off without losing the mode
    en_next = ctrl_reg[CTRL_OUT_EN] ? decodeMode(mode_reg) : 6'h00;
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      codes_reg <= 32'h0;
      mode_reg  <= 4'h0;
      xfer_reg  <= 1'b0;
      en_reg    <= 6'h00;
    end
    else
    begin
      codes_reg <= codes_next;
      mode_reg  <= mode_next;
      xfer_reg  <= xfer_next;
      en_reg    <= en_next;
    end
  end

  // Field N starts at bit 8N+1 of the word, its LSB
  assign pitchCode  = codes_reg[PITCH_LSB  +: CODE_BITS];
  assign yawCode    = codes_reg[YAW_LSB    +: CODE_BITS];
  assign rollCode   = codes_reg[ROLL_LSB   +: CODE_BITS];
  assign redundCode = codes_reg[REDUND_LSB +: CODE_BITS];

  // Enables straight from flops; mixing gates take rate and sun enables
  assign wheel_driver_enable_a = en_reg[0];
  assign wheel_driver_enable_b = en_reg[1];
  assign wheel_driver_enable_c = en_reg[2];
  assign rate_path_enable_a    = en_reg[3];
  assign rate_path_enable_b    = en_reg[4];
  assign sunSensorEnable       = en_reg[5];
  assign modeTelemetry         = en_reg;

  // ***************************************************************
  // APB slave and counters
  // ***************************************************************
  logic [31:0]            rdata_reg, rdata_next;
  logic                   ready_reg, ready_next;
  logic                   err_reg, err_next;
  logic [COUNT_BITS-1:0]  wordCnt_reg, wordCnt_next;
  logic [COUNT_BITS-1:0]  errCnt_reg, errCnt_next;
  logic                   access;
  logic                   wrAccess;
  logic                   clrCnt;

  // One wait state: ready rises in the second access cycle
  assign access   = psel && penable && !ready_reg;
  assign wrAccess = access && pwrite;
  assign clrCnt   = wrAccess && paddr == ADDR_CTRL && pwdata[CTRL_CLR_CNT];

  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rdata_next = 32'h0;
    err_next   = 1'b0;
    ready_next = access;
    // A word landing with the clear still counts: set wins
    wordCnt_next = clrCnt ? 16'h0 : wordCnt_reg;
    errCnt_next  = clrCnt ? 16'h0 : errCnt_reg;
    if (rxValid)
      wordCnt_next = wordCnt_next + 16'h1;
    if (rxError)
      errCnt_next = errCnt_next + 16'h1;
    if (access)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          if (pwrite)
            ctrl_next = pwdata[1:0];
          rdata_next = {30'h0, ctrl_reg};
        end
        ADDR_STATUS:  rdata_next = {21'h0, xfer_reg, mode_reg, en_reg};
        ADDR_WHEELS:  rdata_next = codes_reg;
        ADDR_WORDCNT: rdata_next = {16'h0, wordCnt_reg};
        ADDR_ERRCNT:  rdata_next = {16'h0, errCnt_reg};
        default:      err_next   = 1'b1;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg    <= CTRL_RESET;
      rdata_reg   <= 32'h0;
      ready_reg   <= 1'b0;
      err_reg     <= 1'b0;
      wordCnt_reg <= 16'h0;
      errCnt_reg  <= 16'h0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      rdata_reg   <= rdata_next;
      ready_reg   <= ready_next;
      err_reg     <= err_next;
      wordCnt_reg <= wordCnt_next;
      errCnt_reg  <= errCnt_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = ready_reg;
  assign pslverr = err_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence sLoadMode;
    rxValid && rxWord[XFER_BIT];
  endsequence

  sequence sKeepMode;
    rxValid && !rxWord[XFER_BIT];
  endsequence

  a_pitch_yaw_map: assert property (rxValid |=> pitchCode == $past(rxWord[7:0]) && yawCode == $past(rxWord[15:8]))
    else $error("pitch or yaw code misplaced");
  a_roll_red_map: assert property (rxValid |=> rollCode == $past(rxWord[23:16]) && redundCode == $past(rxWord[31:24]))
    else $error("roll or redundant code misplaced");
  a_code_lsb_order: assert property (rxValid |=> pitchCode[0] == $past(rxWord[0]) && redundCode[7] == $past(rxWord[31]))
    else $error("code bit order wrong");
  a_mode_load: assert property (sLoadMode |=> mode_reg == $past(rxWord[36:33]))
    else $error("mode not loaded with transfer bit");
  a_mode_hold: assert property (sKeepMode |=> $stable(mode_reg))
    else $error("mode changed without transfer bit");
  a_decode_follow: assert property (sLoadMode ##1 ctrl_reg[CTRL_OUT_EN] |=> en_reg == decodeMode($past(mode_reg)))
    else $error("enables do not follow mode");
  a_telem_mirror: assert property (modeTelemetry == ($past(ctrl_reg[CTRL_OUT_EN]) ? decodeMode($past(mode_reg))
                                                     : 6'h00))
    else $error("telemetry differs from decoded mode");
  a_mix_gate_off: assert property (!ctrl_reg[CTRL_OUT_EN] |=> !rate_path_enable_a && !rate_path_enable_b
                                   && !sunSensorEnable)
    else $error("mixing enable on while parked");
  a_apb_wait_one: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

endmodule
`default_nettype wire

// ==== sim/wcd_cmd_sender.sv ====
// Command decoder model: sends serial command words, bit 1 first
`timescale 1ns/1ps
`default_nettype none
module wcd_cmd_sender
  import wcd_pkg::*;
(
  input  wire logic clock,
  output logic      serFrame,
  output logic      serStrobe,
  output logic      serData
);
  // Idle link at time zero
  initial
  begin
    serFrame  = 1'b0;
    serStrobe = 1'b0;
    serData   = 1'b0;
  end

  // ********
  // Word transfer
  // ********
  // Sends nBits of word (bits past 37 wrap to bit 1), gap idle cycles after each strobe;
  // between strobes the data line shows the inverse of the last bit
  task automatic sendWord(input logic [WORD_BITS-1:0] word, input int nBits, input int gap);
    for (int i = 0; i < nBits; i++)
    begin
      @(posedge clock);
      serFrame  <= 1'b1;
      serStrobe <= 1'b1;
      serData   <= word[i % WORD_BITS];
      for (int g = 0; g < gap; g++)
      begin
        @(posedge clock);
        serStrobe <= 1'b0;
        serData   <= ~word[i % WORD_BITS];
      end
    end
    @(posedge clock);
    serFrame  <= 1'b0;
    serStrobe <= 1'b0;
    serData   <= ~serData;
    // Frame must stay low a cycle before the next word
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ==== sim/wcd_top_tb_top.sv ====
// Self-checking bench for the wheel command word decoder
`timescale 1ns/1ps
`default_nettype none
module wcd_top_tb_top;
  import wcd_pkg::*;
  logic        clock;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serFrame;
  logic        serStrobe;
  logic        serData;
  logic [31:0] codes;
  logic [5:0]  enBus;
  logic [5:0]  modeTelemetry;
  logic [31:0] rdVal;
  logic        rdErr;
  int          error_cnt;
  int          tests_run;

  // Design and command decoder model
  wcd_top i_wcd_top (
    .clock                 (clock),
    .arst_n                (arst_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .serFrame              (serFrame),
    .serStrobe             (serStrobe),
    .serData               (serData),
    .pitchCode             (codes[7:0]),
    .yawCode               (codes[15:8]),
    .rollCode              (codes[23:16]),
    .redundCode            (codes[31:24]),
    .wheel_driver_enable_a (enBus[0]),
    .wheel_driver_enable_b (enBus[1]),
    .wheel_driver_enable_c (enBus[2]),
    .rate_path_enable_a    (enBus[3]),
    .rate_path_enable_b    (enBus[4]),
    .sunSensorEnable       (enBus[5]),
    .modeTelemetry         (modeTelemetry)
  );
  wcd_cmd_sender i_wcd_cmd_sender (
    .clock     (clock),
    .serFrame  (serFrame),
    .serStrobe (serStrobe),
    .serData   (serData)
  );

  // 25 MHz clock
  always #20 clock = ~clock;

  // ********
  // Shared tasks
  // ********
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rdVal, exp);
  endtask

  // Full word, then enough edges for codes and enables to settle
  task automatic sendWait(input logic [WORD_BITS-1:0] w, input int gap);
    i_wcd_cmd_sender.sendWord(w, 37, gap);
    repeat (3) @(posedge clock);
  endtask

  task automatic chkOut(input logic [31:0] c, input logic [5:0] en);
    check(codes, c);
    check({26'h0, enBus}, {26'h0, en});
    check({26'h0, modeTelemetry}, {26'h0, en});
  endtask

  // Enable pattern {sun, rateB, rateA, wheelC, wheelB, wheelA} per mode
  function automatic logic [5:0] expEn(input logic [3:0] m);
    case (m)
      4'h1: return 6'h07;
      4'h2: return 6'h0F;
      4'h3: return 6'h1F;
      4'h4: return 6'h3F;
      default: return 6'h00;
    endcase
  endfunction

  // ********
  // Scenarios
  // ********
  task automatic tReset();
    chkOut(32'h0, 6'h00);
    rdChk(ADDR_CTRL, 32'h3);
    rdChk(ADDR_STATUS, 32'h0);
  endtask

  // Asymmetric codes expose swapped fields and reversed bit order
  task automatic tFields();
    sendWait({4'h1, 1'b1, 32'hA53C8001}, 0);
    chkOut(32'hA53C8001, 6'h07);
    rdChk(ADDR_WHEELS, 32'hA53C8001);
    rdChk(ADDR_STATUS, 32'h00000447);
  endtask

  // Every mode code, with prompt and slow senders
  task automatic tModes();
    logic [3:0] m;
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      sendWait({m, 1'b1, {4{m, ~m}}}, i % 3);
      chkOut({4{m, ~m}}, expEn(m));
      rdChk(ADDR_STATUS, {21'h0, 1'b1, m, expEn(m)});
    end
  endtask

  // Mode field held while the transfer bit is clear
  task automatic tXfer();
    sendWait({4'h4, 1'b1, 32'h11223344}, 1);
    sendWait({4'h1, 1'b0, 32'h55667788}, 0);
    chkOut(32'h55667788, 6'h3F);
    sendWait({4'h0, 1'b1, 32'h55667788}, 0);
    chkOut(32'h55667788, 6'h00);
  endtask

  // Cut-short frame never reaches the outputs; an overlong frame delivers its word and is flagged
  task automatic tPartial();
    apb(ADDR_CTRL, 1'b1, 32'h7);
    i_wcd_cmd_sender.sendWord(37'h1FFFFFFFFF, 20, 0);
    repeat (3) @(posedge clock);
    chkOut(32'h55667788, 6'h00);
    rdChk(ADDR_ERRCNT, 32'h1);
    rdChk(ADDR_WORDCNT, 32'h0);
    sendWait({4'h2, 1'b1, 32'hFF00FF00}, 0);
    rdChk(ADDR_WORDCNT, 32'h1);
    i_wcd_cmd_sender.sendWord({4'h2, 1'b1, 32'hFF00FF00}, 38, 0);
    repeat (3) @(posedge clock);
    rdChk(ADDR_WORDCNT, 32'h2);
    rdChk(ADDR_ERRCNT, 32'h2);
    chkOut(32'hFF00FF00, 6'h0F);
  endtask

  // Unmapped and read-only accesses, output and receive disables
  task automatic tControl();
    apb(8'h14, 1'b0, 32'h0);
    check({31'h0, rdErr}, 32'h1);
    check(rdVal, 32'h0);
    apb(ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
    rdChk(ADDR_STATUS, 32'h0000048F);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    repeat (3) @(posedge clock);
    check({26'h0, enBus}, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h2);
    sendWait({4'h4, 1'b1, 32'h12345678}, 0);
    chkOut(32'hFF00FF00, 6'h0F);
    apb(ADDR_CTRL, 1'b1, 32'h3);
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    clock     = 1'b0;
    arst_n    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    tReset();
    tFields();
    tModes();
    tXfer();
    tPartial();
    tControl();
    report_and_stop();
  end

  // Watchdog: the run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
